// *** hw/lsk_top.sv ***
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module lsk_top
	import lsk_pkg::*;
(
	input  wire logic                          sys_clk_i,         // 100 mhz clock
	input  wire logic                          rst_i,             // async reset, high
	input  wire logic                          psel_i,            // apb select
	input  wire logic                          penable_i,         // apb enable
	input  wire logic                          pwrite_i,          // apb direction
	input  wire logic [7:0]                    paddr_i,           // apb byte address
	input  wire logic [31:0]                   pwdata_i,          // apb write data
	output logic      [31:0]                   prdata_o,          // apb read data
	output logic                               pready_o,          // apb ready
	output logic                               pslverr_o,         // apb error
	output logic                               irq_o,             // level interrupt
	input  wire logic                          key_scan_valid_i,  // scan engine confirms keys
	input  wire logic [lsk_pkg::KEY_BITS-1:0]  key_scan_data_i,   // confirmed key matrix
	input  wire logic                          chip_enable_i,     // link enable pin
	input  wire logic                          serial_clock_pin_i,   // link clock pin
	input  wire logic                          serial_data_in_pin_i, // link data pin
	output logic                               do_o,              // data-out level, always 0
	output logic                               do_oe_o,           // data-out pulled low
	output logic      [lsk_pkg::SEG_NUM*lsk_pkg::COMMONS-1:0] seg_o, // segment/common bits
	output logic                               com4_active_o,     // shared pin is common four
	output logic                               osc_rc_en_o,       // oscillator pin rc mode
	output logic                               osc_ext_en_o,      // oscillator pin ext clock
	output logic                               sleep_select_o,    // sleep mode selected
	output logic                               key_read_req_o     // read request pending
);
	//////////////////////////////////////////////////////////////////////////
	logic [CTRL_W-1:0]        ctrl_reg, ctrl_next;
	logic [IRQ_W-1:0]         irq_stat_reg, irq_stat_next;
	logic [IRQ_W-1:0]         irq_mask_reg, irq_mask_next;
	logic [31:0]              disp_shadow_reg [DISP_WORDS];
	logic [31:0]              disp_shadow_next [DISP_WORDS];
	logic [DISP_BITS-1:0]     disp_active_reg, disp_active_next;
	logic [31:0]              prdata_reg, prdata_next;
	logic                     pslverr_reg, pslverr_next;
	logic                     commit_pulse;
	logic                     wr_en, rd_setup;
	logic [DISP_BITS-1:0]     shadow_flat;
	logic [SEG_NUM*COMMONS-1:0] seg_map, seg_reg;

	logic [KEY_BITS-1:0]      key_reg, key_next;
	logic                     sleep_ack_reg, sleep_ack_next;
	logic                     key_req_reg, key_req_next;
	logic [KEY_BITS-1:0]      key_masked;
	logic [1:0]               reassign_code;

	lsk_link_state_type       lnk_state_reg, lnk_state_next;
	logic [ADDR_BITS-1:0]     addr_reg, addr_next;
	logic [3:0]               addr_cnt_reg, addr_cnt_next;
	logic [4:0]               out_idx_reg, out_idx_next;
	logic                     rise_seen_reg, rise_seen_next;
	logic                     do_oe_reg, do_oe_next;
	logic                     read_done;
	logic                     ce_s, lclk_s, ldat_s;
	logic                     ce_d_reg, lclk_d_reg;
	logic                     ce_rise, ce_fall, lclk_rise, lclk_fall;
	logic [OUT_BITS-1:0]      out_vec;

	//////////////////////////////////////////////////////////////////////////
	// link pins cross into the system clock
	lsk_sync2 #(.STAGES(SYNC_STAGES)) u_sync_ce (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d_i       (chip_enable_i),
		.q_o       (ce_s)
	);
	lsk_sync2 #(.STAGES(SYNC_STAGES)) u_sync_lclk (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d_i       (serial_clock_pin_i),
		.q_o       (lclk_s)
	);
	lsk_sync2 #(.STAGES(SYNC_STAGES)) u_sync_ldat (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d_i       (serial_data_in_pin_i),
		.q_o       (ldat_s)
	);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ce_d_reg <= 1'b0;
			lclk_d_reg <= 1'b0;
		end else begin
			ce_d_reg <= ce_s;
			lclk_d_reg <= lclk_s;
		end
	end

	assign ce_rise = ce_s & ~ce_d_reg;
	assign ce_fall = ~ce_s & ce_d_reg;
	assign lclk_rise = lclk_s & ~lclk_d_reg;
	assign lclk_fall = ~lclk_s & lclk_d_reg;

	//////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states, read data prepared in the setup cycle
	assign wr_en    = psel_i & penable_i & pwrite_i;
	assign rd_setup = psel_i & ~penable_i & ~pwrite_i;

	always_comb begin
		logic hit;
		hit           = 1'b1;
		commit_pulse  = 1'b0;
		ctrl_next     = ctrl_reg;
		irq_mask_next = irq_mask_reg;
		prdata_next   = prdata_reg;
		pslverr_next  = 1'b0;
		disp_shadow_next = disp_shadow_reg;
		if (paddr_i == OFF_CTRL) begin
			prdata_next = {27'h0, ctrl_reg};
			// mode write takes effect at once
			if (wr_en) begin
				ctrl_next = pwdata_i[CTRL_W-1:0];
			end
		end else if (paddr_i == OFF_STATUS) begin
			prdata_next = {26'h0, lnk_state_reg, rise_seen_reg, do_oe_reg,
				sleep_ack_reg, key_req_reg};
		end else if (paddr_i == OFF_KEY) begin
			prdata_next = {1'b0, sleep_ack_reg, key_reg};
		end else if (paddr_i == OFF_IRQ_STAT) begin
			prdata_next = {30'h0, irq_stat_reg};
		end else if (paddr_i == OFF_IRQ_MASK) begin
			prdata_next = {30'h0, irq_mask_reg};
			if (wr_en) begin
				irq_mask_next = pwdata_i[IRQ_W-1:0];
			end
		end else if (paddr_i == OFF_DISP_COMMIT) begin
			prdata_next  = 32'h0;
			commit_pulse = wr_en & pwdata_i[0];
		end else if (paddr_i >= OFF_DISP_BASE && paddr_i < OFF_DISP_BASE + 8'h18
			&& paddr_i[1:0] == 2'h0) begin
			prdata_next = disp_shadow_reg[3'(paddr_i[4:2])];
			if (wr_en) begin
				disp_shadow_next[3'(paddr_i[4:2])] = pwdata_i;
			end
		end else begin
			hit         = 1'b0;
			prdata_next = 32'h0;
		end
		if (!rd_setup) begin
			prdata_next = prdata_reg;
		end
		pslverr_next = psel_i & ~penable_i & ~hit;
	end

	for (genvar w = 0; w < DISP_WORDS; w++) begin : g_flat
		if (w < DISP_WORDS - 1) begin : g_full
			assign shadow_flat[32*w+31:32*w] = disp_shadow_reg[w];
		end else begin : g_tail
			assign shadow_flat[DISP_BITS-1:32*w] = disp_shadow_reg[w][DISP_BITS-32*w-1:0];
		end
	end

	// active bits swap only on commit
	assign disp_active_next = commit_pulse ? shadow_flat : disp_active_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_reg        <= CTRL_RESET;
			irq_mask_reg    <= IRQ_MASK_RESET;
			prdata_reg      <= 32'h0;
			pslverr_reg     <= 1'b0;
			disp_active_reg <= '0;
			disp_shadow_reg <= '{default: 32'h0};
		end else begin
			ctrl_reg        <= ctrl_next;
			irq_mask_reg    <= irq_mask_next;
			prdata_reg      <= prdata_next;
			pslverr_reg     <= pslverr_next;
			disp_active_reg <= disp_active_next;
			disp_shadow_reg <= disp_shadow_next;
		end
	end

	assign prdata_o  = prdata_reg;
	assign pready_o  = 1'b1;
	assign pslverr_o = pslverr_reg & psel_i & penable_i;

	//////////////////////////////////////////////////////////////////////////
	// segment mapping, registered so pins never see a partial update
	lsk_seg_map u_seg_map (
		.disp_i  (disp_active_reg),
		.duty3_i (ctrl_reg[CTRL_DUTY_BIT]),
		.seg_o   (seg_map)
	);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			seg_reg <= '0;
		end else begin
			seg_reg <= seg_map;
		end
	end

	assign seg_o          = seg_reg;
	assign com4_active_o  = ~ctrl_reg[CTRL_DUTY_BIT];
	assign osc_rc_en_o    = ~ctrl_reg[CTRL_OSC_BIT];
	assign osc_ext_en_o   = ctrl_reg[CTRL_OSC_BIT];
	assign sleep_select_o = ctrl_reg[CTRL_SLEEP_BIT];

	//////////////////////////////////////////////////////////////////////////
	// key capture; a held request ignores newer scans
	assign reassign_code = {ctrl_reg[CTRL_RSG_LO_BIT], ctrl_reg[CTRL_RSG_HI_BIT]};

	always_comb begin
		key_masked = key_scan_data_i;
		// rows given to segments read zero
		for (int b = 0; b < KEY_BITS; b++) begin
			if (b < KEY_COLS * int'(reassign_code)) begin
				key_masked[b] = 1'b0;
			end
		end
	end

	always_comb begin
		key_next       = key_reg;
		sleep_ack_next = sleep_ack_reg;
		key_req_next   = key_req_reg;
		// capture only when no request is held
		if (key_scan_valid_i && !key_req_reg) begin
			// matrix bit order from scan engine
			key_next       = key_masked;
			sleep_ack_next = ctrl_reg[CTRL_SLEEP_BIT];
			key_req_next   = 1'b1;
		end else if (read_done) begin
			key_req_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			key_reg       <= '0;
			sleep_ack_reg <= 1'b0;
			key_req_reg   <= 1'b0;
		end else begin
			key_reg       <= key_next;
			sleep_ack_reg <= sleep_ack_next;
			key_req_reg   <= key_req_next;
		end
	end

	assign key_read_req_o = key_req_reg;

	//////////////////////////////////////////////////////////////////////////
	// serial link: address while enable low, key word while enable high
	assign out_vec   = {sleep_ack_reg, key_reg};
	assign read_done = ce_fall & (lnk_state_reg == LNK_OUT);

	always_comb begin
		lnk_state_next = lnk_state_reg;
		addr_next      = addr_reg;
		addr_cnt_next  = addr_cnt_reg;
		out_idx_next   = out_idx_reg;
		rise_seen_next = rise_seen_reg;
		case (lnk_state_reg)
			LNK_IDLE: begin
				// enable idles low, so a low level arms address capture
				if (!ce_s) begin
					lnk_state_next = LNK_ADDR;
					addr_cnt_next  = 4'h0;
				end
			end
			LNK_ADDR: begin
				// last eight bits before enable rises form the address
				if (lclk_rise) begin
					addr_next = {ldat_s, addr_reg[ADDR_BITS-1:1]};
					if (addr_cnt_reg < 4'(ADDR_BITS)) begin
						addr_cnt_next = addr_cnt_reg + 4'h1;
					end
				end
				if (ce_rise) begin
					out_idx_next   = 5'h0;
					rise_seen_next = 1'b0;
					if (addr_cnt_reg == 4'(ADDR_BITS) && addr_reg == KEY_READ_ADDR) begin
						lnk_state_next = LNK_OUT;
					end else begin
						lnk_state_next = LNK_IDLE;
					end
				end
			end
			LNK_OUT: begin
				// a falling edge counts only after a rising one
				if (lclk_rise) begin
					rise_seen_next = 1'b1;
				end else if (lclk_fall && rise_seen_reg) begin
					rise_seen_next = 1'b0;
					if (out_idx_reg < 5'(OUT_BITS)) begin
						out_idx_next = out_idx_reg + 5'h1;
					end
				end
				if (ce_fall) begin
					lnk_state_next = LNK_ADDR;
					addr_cnt_next  = 4'h0;
				end
			end
			default: begin
				lnk_state_next = LNK_IDLE;
			end
		endcase
	end

	always_comb begin
		if (lnk_state_next == LNK_OUT) begin
			do_oe_next = (out_idx_next < 5'(OUT_BITS)) ? ~out_vec[out_idx_next] : 1'b0;
		end else begin
			// request low only while enable low
			do_oe_next = key_req_next & ~ce_s;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lnk_state_reg <= LNK_IDLE;
			addr_reg      <= '0;
			addr_cnt_reg  <= 4'h0;
			out_idx_reg   <= 5'h0;
			rise_seen_reg <= 1'b0;
			do_oe_reg     <= 1'b0;
		end else begin
			lnk_state_reg <= lnk_state_next;
			addr_reg      <= addr_next;
			addr_cnt_reg  <= addr_cnt_next;
			out_idx_reg   <= out_idx_next;
			rise_seen_reg <= rise_seen_next;
			do_oe_reg     <= do_oe_next;
		end
	end

	assign do_o    = 1'b0;
	assign do_oe_o = do_oe_reg;

	//////////////////////////////////////////////////////////////////////////
	// interrupts: set beats a same-cycle write-one clear
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_en && paddr_i == OFF_IRQ_STAT) begin
			irq_stat_next = irq_stat_reg & ~pwdata_i[IRQ_W-1:0];
		end
		if (key_req_next && !key_req_reg) begin
			irq_stat_next[IRQ_REQ_BIT] = 1'b1;
		end
		if (read_done) begin
			irq_stat_next[IRQ_DONE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= irq_stat_next;
		end
	end

	assign irq_o = |(irq_stat_reg & irq_mask_reg);

	//////////////////////////////////////////////////////////////////////////
	property p_osc_pin;
		@(posedge sys_clk_i) disable iff (rst_i)
		osc_rc_en_o == !ctrl_reg[CTRL_OSC_BIT] && osc_ext_en_o == ctrl_reg[CTRL_OSC_BIT];
	endproperty
	a_osc_pin: assert property (p_osc_pin) else $error("oscillator pin mode wrong");

	property p_seg39_dark;
		@(posedge sys_clk_i) disable iff (rst_i)
		!ctrl_reg[CTRL_DUTY_BIT] && $stable(ctrl_reg) |=> seg_o[155:152] == 4'h0;
	endproperty
	a_seg39_dark: assert property (p_seg39_dark) else $error("segment 39 driven");

	property p_com4_role;
		@(posedge sys_clk_i) disable iff (rst_i)
		com4_active_o != ctrl_reg[CTRL_DUTY_BIT];
	endproperty
	a_com4_role: assert property (p_com4_role) else $error("shared pin role wrong");

	property p_disp_hold;
		@(posedge sys_clk_i) disable iff (rst_i)
		!$past(commit_pulse) |-> $stable(disp_active_reg);
	endproperty
	a_disp_hold: assert property (p_disp_hold) else $error("display changed early");

	property p_key_stable;
		@(posedge sys_clk_i) disable iff (rst_i)
		key_req_reg && $past(key_req_reg) |-> $stable(key_reg) && $stable(sleep_ack_reg);
	endproperty
	a_key_stable: assert property (p_key_stable) else $error("key word moved");

	property p_sleep_ack;
		@(posedge sys_clk_i) disable iff (rst_i)
		$rose(key_req_reg) |-> sleep_ack_reg == $past(ctrl_reg[CTRL_SLEEP_BIT]);
	endproperty
	a_sleep_ack: assert property (p_sleep_ack) else $error("sleep bit not captured");

	property p_rows_zero;
		@(posedge sys_clk_i) disable iff (rst_i)
		$rose(key_req_reg) && $past(reassign_code) == 2'h2 |-> key_reg[9:0] == 10'h000;
	endproperty
	a_rows_zero: assert property (p_rows_zero) else $error("reassigned rows not zero");

	property p_key_bits;
		@(posedge sys_clk_i) disable iff (rst_i)
		$rose(key_req_reg) |-> key_reg[29:15] == $past(key_scan_data_i[29:15]);
	endproperty
	a_key_bits: assert property (p_key_bits) else $error("key bits misplaced");

	property p_out_addr;
		@(posedge sys_clk_i) disable iff (rst_i)
		lnk_state_reg == LNK_OUT && $past(lnk_state_reg) != LNK_OUT
			|-> $past(addr_reg) == KEY_READ_ADDR;
	endproperty
	a_out_addr: assert property (p_out_addr) else $error("read without address");

	property p_ce_release;
		@(posedge sys_clk_i) disable iff (rst_i)
		ce_s && lnk_state_reg != LNK_OUT ##1 lnk_state_reg != LNK_OUT |-> !do_oe_reg;
	endproperty
	a_ce_release: assert property (p_ce_release) else $error("data-out low under enable");

	property p_req_low;
		@(posedge sys_clk_i) disable iff (rst_i)
		key_req_reg && !ce_s && lnk_state_reg == LNK_ADDR ##1 key_req_reg && !ce_s
			&& lnk_state_reg == LNK_ADDR |-> do_oe_reg;
	endproperty
	a_req_low: assert property (p_req_low) else $error("request not on data-out");
endmodule

// *** hw/lsk_pkg.sv ***
package lsk_pkg;
	// apb register map
	localparam logic [7:0] OFF_CTRL        = 8'h00;
	localparam logic [7:0] OFF_STATUS      = 8'h04;
	localparam logic [7:0] OFF_KEY         = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT    = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h10;
	localparam logic [7:0] OFF_DISP_COMMIT = 8'h14;
	localparam logic [7:0] OFF_DISP_BASE   = 8'h20;
	localparam int         DISP_WORDS      = 6;
	localparam int         DISP_BITS       = 164;
	localparam int         SEG_NUM         = 42;
	localparam int         COMMONS         = 4;
	localparam int         KEY_BITS        = 30;
	localparam int         KEY_COLS        = 5;
	// control register fields
	localparam int         CTRL_OSC_BIT    = 0;
	localparam int         CTRL_DUTY_BIT   = 1;
	localparam int         CTRL_RSG_LO_BIT = 2;
	localparam int         CTRL_RSG_HI_BIT = 3;
	localparam int         CTRL_SLEEP_BIT  = 4;
	localparam int         CTRL_W          = 5;
	localparam logic [4:0] CTRL_RESET      = 5'h00;
	// interrupt fields
	localparam int         IRQ_REQ_BIT     = 0;
	localparam int         IRQ_DONE_BIT    = 1;
	localparam int         IRQ_W           = 2;
	localparam logic [1:0] IRQ_MASK_RESET  = 2'h0;
	// serial link
	localparam logic [7:0] KEY_READ_ADDR   = 8'h43;
	localparam int         ADDR_BITS       = 8;
	localparam int         OUT_BITS        = 31;
	localparam int         SYNC_STAGES     = 2;
	typedef enum logic [1:0] {
		LNK_IDLE = 2'b00,
		LNK_ADDR = 2'b01,
		LNK_OUT  = 2'b11
	} lsk_link_state_type;
endpackage

// *** hw/lsk_sync2.sv ***
`timescale 1ns/1ns
module lsk_sync2 #(
	parameter int STAGES = 2
) (
	input  wire logic sys_clk_i, // system clock
	input  wire logic rst_i,     // async reset, high
	input  wire logic d_i,       // asynchronous level
	output logic      q_o        // synchronised level
);
	logic [STAGES-1:0] sync_reg;

	// first stage feeds only the second
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= {sync_reg[STAGES-2:0], d_i};
		end
	end

	assign q_o = sync_reg[STAGES-1];
endmodule

// *** hw/lsk_seg_map.sv ***
`timescale 1ns/1ns
module lsk_seg_map
	import lsk_pkg::*;
(
	input  wire logic [lsk_pkg::DISP_BITS-1:0]         disp_i,  // committed display bits
	input  wire logic                                  duty3_i, // 1: three commons
	output logic      [lsk_pkg::SEG_NUM*lsk_pkg::COMMONS-1:0] seg_o // 4 bits per segment
);
	for (genvar i = 0; i < SEG_NUM; i++) begin : g_seg
		for (genvar c = 0; c < COMMONS; c++) begin : g_com
			logic four_bit;
			if (i < 38) begin : g_lo
				assign four_bit = disp_i[4*i+c];
			end else if (i == 38) begin : g_c4
				assign four_bit = 1'b0;
			end else begin : g_hi
				assign four_bit = disp_i[152+4*(i-39)+c];
			end
			if (c < 3) begin : g_three
				assign seg_o[4*i+c] = duty3_i ? disp_i[3*i+c] : four_bit;
			end else begin : g_nothree
				assign seg_o[4*i+c] = duty3_i ? 1'b0 : four_bit;
			end
		end
	end
endmodule

// *** tb/lsk_ctrl_model.sv ***
`timescale 1ns/1ns
module lsk_ctrl_model (
	input  wire logic do_line_i, // pulled-up data-out line
	output logic      ce_o,      // link enable
	output logic      lclk_o,    // link clock
	output logic      ldat_o     // link data
);
	logic idle_hi;
	initial begin
		ce_o = 1'b0;
		lclk_o = 1'b0;
		ldat_o = 1'b0;
		idle_hi = 1'b0;
	end
	task automatic set_idle(input logic hi);
		idle_hi = hi;
		lclk_o = hi;
		#250;
	endtask
	// address b0 first, then 31 bits back
	task automatic read_keys(input logic [7:0] addr, output logic [30:0] bits);
		ce_o = 1'b0;
		for (int i = 0; i < 8; i++) begin
			lclk_o = 1'b0;
			ldat_o = addr[i];
			#63;
			lclk_o = 1'b1;
			#62;
		end
		lclk_o = idle_hi;
		#63;
		ce_o = 1'b1;
		#62;
		for (int i = 0; i < 31; i++) begin
			lclk_o = 1'b0;
			#63;
			// line low means bit 0
			bits[i] = do_line_i;
			lclk_o = 1'b1;
			#62;
		end
		lclk_o = idle_hi;
		#63;
		ce_o = 1'b0;
		#62;
	endtask
endmodule

// *** tb/lsk_top_bench.sv ***
`timescale 1ns/1ns
module lsk_top_bench;
	import lsk_pkg::*;
	logic         sys_clk_i, rst_i, psel_i, penable_i, pwrite_i;
	logic [7:0]   paddr_i;
	logic [31:0]  pwdata_i, prdata_o;
	logic         pready_o, pslverr_o, irq_o, key_scan_valid_i;
	logic [29:0]  key_scan_data_i;
	logic         chip_enable_i, serial_clock_pin_i, serial_data_in_pin_i;
	logic         do_o, do_oe_o, com4_active_o, osc_rc_en_o, osc_ext_en_o;
	logic         sleep_select_o, key_read_req_o, do_line;
	logic [167:0] seg_o;
	int           fail_count, checks;
	// open drain with pull-up
	assign do_line = do_oe_o ? do_o : 1'b1;
	lsk_top u_lsk_top (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .key_scan_valid_i,
		.key_scan_data_i, .chip_enable_i, .serial_clock_pin_i, .serial_data_in_pin_i,
		.do_o, .do_oe_o, .seg_o, .com4_active_o, .osc_rc_en_o, .osc_ext_en_o,
		.sleep_select_o, .key_read_req_o);
	lsk_ctrl_model u_lsk_ctrl_model (.do_line_i(do_line), .ce_o(chip_enable_i),
		.lclk_o(serial_clock_pin_i), .ldat_o(serial_data_in_pin_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		for (int n = 0; n <= 50; n++) begin
			@(posedge sys_clk_i);
			if (pready_o === 1'b1) break;
			if (n == 50) begin
				fail_count++;
				$display("MISMATCH %0t apb timeout", $time);
				print_verdict();
			end
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		// the write lands at the access edge; callers sample after it
		@(posedge sys_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		apb(1'b0, a, 32'h0, d, e);
	endtask
	task automatic press(input logic [29:0] k);
		@(posedge sys_clk_i);
		key_scan_valid_i <= 1'b1;
		key_scan_data_i <= k;
		@(posedge sys_clk_i);
		key_scan_valid_i <= 1'b0;
	endtask
	task automatic wait_req(input logic v);
		for (int n = 0; n < 300; n++) begin
			@(posedge sys_clk_i);
			if (key_read_req_o === v) return;
		end
		fail_count++;
		$display("MISMATCH %0t request timeout", $time);
		print_verdict();
	endtask
	//////////////////////////////////////////////////////////////////////////
	task automatic t_ctrl();
		logic [31:0] r;
		logic        e;
		chk({30'h0, osc_rc_en_o, com4_active_o}, 32'h3, "reset pins");
		wr(OFF_CTRL, 32'h3);
		rd(OFF_CTRL, r);
		chk(r, 32'h3, "ctrl");
		chk({29'h0, osc_ext_en_o, osc_rc_en_o, com4_active_o}, 32'h4, "osc duty");
		apb(1'b0, 8'hfc, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1, "unmapped");
		wr(OFF_CTRL, 32'h0);
	endtask
	task automatic t_disp();
		logic [191:0] dv;
		logic [167:0] e, m;
		for (int w = 0; w < DISP_WORDS; w++) begin
			dv[32*w +: 32] = 32'h8c3a_5f17 ^ (32'(w) * 32'h1f2e_3d4c);
			wr(OFF_DISP_BASE + 8'(4 * w), dv[32*w +: 32]);
		end
		chk(seg_o[31:0], 32'h0, "shadow leaked");
		wr(OFF_DISP_COMMIT, 32'h1);
		for (int t = 0; t < 2; t++) begin
			wr(OFF_CTRL, 32'(t) << CTRL_DUTY_BIT);
			repeat (3) @(posedge sys_clk_i);
			e = '0;
			m = '0;
			for (int s = 0; s < SEG_NUM; s++) begin
				for (int c = 0; c < 4; c++) begin
					if (t == 1 && c < 3) begin
						e[4*s+c] = dv[3*s+c];
						m[4*s+c] = 1'b1;
					end
					if (t == 0 && s != 38) begin
						e[4*s+c] = dv[s < 38 ? 4*s+c : 4*s+c-4];
						m[4*s+c] = 1'b1;
					end
				end
			end
			checks++;
			if ((seg_o & m) !== e) begin
				fail_count++;
				$display("MISMATCH %0t segment map, duty %0d", $time, t);
			end
		end
		wr(OFF_DISP_BASE, ~dv[31:0]);
		repeat (3) @(posedge sys_clk_i);
		chk({31'h0, seg_o[0]}, {31'h0, dv[0]}, "early update");
		wr(OFF_DISP_COMMIT, 32'h1);
		repeat (3) @(posedge sys_clk_i);
		chk({31'h0, seg_o[0]}, {31'h0, ~dv[0]}, "commit");
		wr(OFF_CTRL, 32'h0);
	endtask
	task automatic t_keys();
		logic [31:0] r;
		logic [30:0] b;
		wr(OFF_IRQ_MASK, 32'h0);
		press(30'h1 << 11);
		wait_req(1'b1);
		repeat (2) @(posedge sys_clk_i);
		chk({30'h0, do_line, irq_o}, 32'h0, "line low, irq masked");
		wr(OFF_IRQ_MASK, 32'h3);
		chk({31'h0, irq_o}, 32'h1, "irq unmasked");
		press(30'h3fff_ffff);
		rd(OFF_KEY, r);
		chk(r, 32'h0000_0800, "key word");
		u_lsk_ctrl_model.read_keys(8'h42, b);
		chk({1'b0, b}, 32'h7fff_ffff, "wrong address");
		chk({31'h0, do_line}, 32'h0, "still pending");
		u_lsk_ctrl_model.read_keys(KEY_READ_ADDR, b);
		chk({1'b0, b}, 32'h0000_0800, "serial keys");
		wait_req(1'b0);
		rd(OFF_IRQ_STAT, r);
		chk({r[30:0], do_line}, 32'h7, "released, irq");
		wr(OFF_IRQ_STAT, 32'h3);
		chk({31'h0, irq_o}, 32'h0, "irq cleared");
	endtask
	task automatic t_sleep();
		logic [30:0] b;
		wr(OFF_CTRL, 32'h14);
		u_lsk_ctrl_model.set_idle(1'b1);
		press(30'h3fff_ffff);
		wait_req(1'b1);
		wr(OFF_CTRL, 32'h04);
		chk({31'h0, sleep_select_o}, 32'h0, "mode adopted");
		u_lsk_ctrl_model.read_keys(KEY_READ_ADDR, b);
		chk({1'b0, b}, 32'h7fff_fc00, "sleep keys");
		wait_req(1'b0);
		u_lsk_ctrl_model.set_idle(1'b0);
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		fail_count = 0;
		checks = 0;
		rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		key_scan_valid_i = 1'b0;
		key_scan_data_i = 30'h0;
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_ctrl();
		t_disp();
		t_keys();
		t_sleep();
		print_verdict();
	end
endmodule
